/* File: inc/wds_pkg.sv */
// Function
// R1: time base counts cpu clock cycles
// R2: three-bit period field, 16K doubling to 2048K
// R3: period scaled by divider setting plus one
// R4: 14-bit counter behind a 7-bit prescaler
// R5: every reset and power-down stop the watchdog
// R6: unfed time-out pulses the cpu reset
// R7: 1eh then e1h starts the watchdog
// R8: running bit is read-only, shows live state
// R9: software feeds 1eh/e1h before each time-out
// R10: no other register write inside a sequence
// R11: a wrong enable or feed resets at once
// R12: 5ah then a5h forces software reset, flag set
// R13: any other sequence resets, sets both flags
// R14: time-out sets overflow; flags stay until cleared
// R15: idle-freeze bit stops counting during idle
// R16: own resets keep flags, clear enable and count
// R17: sequence is two writes; mismatch is an error
package wds_pkg;

  // register offsets on the special-function bus
  localparam logic [7:0] WDS_SEQ_ADDR = 8'ha6;
  localparam logic [7:0] WDS_CTL_ADDR = 8'ha7;

  // control/status field positions
  localparam int WDS_PS_MSB = 7;
  localparam int WDS_PS_LSB = 5;
  localparam int WDS_IDLE_BIT = 4;
  localparam int WDS_SWR_BIT = 2;
  localparam int WDS_OVF_BIT = 1;
  localparam int WDS_RUN_BIT = 0;

  // reset values
  localparam logic [2:0] WDS_PS_RST = 3'h0;
  localparam logic WDS_IDLE_RST = 1'b0;
  localparam logic WDS_FLAG_RST = 1'b0;
  localparam logic WDS_RUN_RST = 1'b0;
  localparam logic [7:0] WDS_RDATA_RST = 8'h00;

  // sequence bytes
  localparam logic [7:0] WDS_FEED_1 = 8'h1e;
  localparam logic [7:0] WDS_FEED_2 = 8'he1;
  localparam logic [7:0] WDS_SWR_1 = 8'h5a;
  localparam logic [7:0] WDS_SWR_2 = 8'ha5;

  // counter widths
  localparam int WDS_PRE_W = 7;
  localparam int WDS_CNT_W = 14;
  localparam int WDS_TPS_W = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } wds_sfr_req_t;

  typedef enum {
    WDS_SEQ_IDLE,
    WDS_SEQ_FEED,
    WDS_SEQ_SWR
  } wds_seq_t;

endpackage : wds_pkg

/* File: rtl/wds_watchdog.sv */
`timescale 1ns/100ps
module wds_watchdog (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // special-function register port
  input wire wds_pkg::wds_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // cpu state and system timer divider
  input wire logic [wds_pkg::WDS_TPS_W-1:0] system_timer_divider_setting,
  input wire logic cpu_idle,
  input wire logic cpu_power_down,
  input wire logic sys_reset,
  // reset request to the cpu
  output logic cpu_reset_pulse
);
  import wds_pkg::*;

  wds_seq_t seq_reg;
  wds_seq_t seq_next;
  logic [2:0] ps_reg;
  logic idle_frz_reg;
  logic swr_flag_reg;
  logic ovf_flag_reg;
  logic run_reg;
  logic [WDS_TPS_W-1:0] tps_cnt_reg;
  logic [WDS_PRE_W-1:0] pre_reg;
  logic [WDS_CNT_W-1:0] cnt_reg;
  logic [7:0] rdata_reg;
  logic rst_pulse_reg;

  logic seq_wr;
  logic ctl_wr;
  logic other_wr;
  logic seq_feed;
  logic seq_swr;
  logic seq_err;
  logic advance;
  logic tick;
  logic pre_tick;
  logic [WDS_PRE_W-1:0] pre_mask;
  logic timeout;
  logic self_rst;
  logic rst_all;
  logic [7:0] ctl_value;

  assign seq_wr = sfr_req.wr && (sfr_req.addr == WDS_SEQ_ADDR);
  assign ctl_wr = sfr_req.wr && (sfr_req.addr == WDS_CTL_ADDR);
  assign other_wr = sfr_req.wr && (sfr_req.addr != WDS_SEQ_ADDR);

  // two-write sequence checker; reads between the writes are harmless
  always_comb begin
    seq_next = seq_reg;
    seq_feed = 1'b0;
    seq_swr = 1'b0;
    seq_err = 1'b0;
    case (seq_reg)
      WDS_SEQ_IDLE: begin
        if (seq_wr) begin
          if (sfr_req.wdata == WDS_FEED_1) begin
            seq_next = WDS_SEQ_FEED; // [R17]
          end else if (sfr_req.wdata == WDS_SWR_1) begin
            seq_next = WDS_SEQ_SWR; // [R17]
          end else begin
            seq_err = 1'b1; // [R13] [R17]
          end
        end
      end
      WDS_SEQ_FEED: begin
        if (seq_wr) begin
          seq_next = WDS_SEQ_IDLE;
          if (sfr_req.wdata == WDS_FEED_2) begin
            seq_feed = 1'b1; // [R7]
          end else begin
            seq_err = 1'b1; // [R11] [R17]
          end
        end else if (other_wr) begin
          // a foreign write breaks the pair, same as a bad byte
          seq_next = WDS_SEQ_IDLE;
          seq_err = 1'b1; // [R10] [R11]
        end
      end
      WDS_SEQ_SWR: begin
        if (seq_wr) begin
          seq_next = WDS_SEQ_IDLE;
          if (sfr_req.wdata == WDS_SWR_2) begin
            seq_swr = 1'b1; // [R12]
          end else begin
            seq_err = 1'b1; // [R13] [R17]
          end
        end else if (other_wr) begin
          seq_next = WDS_SEQ_IDLE;
          seq_err = 1'b1; // [R10] [R13]
        end
      end
      default: begin
        seq_next = WDS_SEQ_IDLE;
      end
    endcase
  end

  // counting stops in power-down, and in idle when frozen
  assign advance = run_reg && !cpu_power_down &&
                   !(cpu_idle && idle_frz_reg); // [R5] [R15]
  // cpu cycles divided by the system timer setting plus one
  assign tick = advance && (tps_cnt_reg == system_timer_divider_setting); // [R1] [R3]
  assign pre_mask = WDS_PRE_W'(~(7'h7f << ps_reg)); // [R2]
  assign pre_tick = tick && ((pre_reg & pre_mask) == pre_mask); // [R4]
  // a feed in the last cycle still rescues the count
  assign timeout = pre_tick && (&cnt_reg) && !seq_feed; // [R6]
  assign self_rst = timeout || seq_swr || seq_err;
  assign rst_all = self_rst || sys_reset;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_reg <= WDS_SEQ_IDLE;
    end else if (rst_all) begin
      seq_reg <= WDS_SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // configuration bits go back to reset values on any reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ps_reg <= WDS_PS_RST;
      idle_frz_reg <= WDS_IDLE_RST;
    end else if (rst_all) begin
      ps_reg <= WDS_PS_RST;
      idle_frz_reg <= WDS_IDLE_RST;
    end else if (ctl_wr) begin
      ps_reg <= sfr_req.wdata[WDS_PS_MSB:WDS_PS_LSB]; // [R2]
      idle_frz_reg <= sfr_req.wdata[WDS_IDLE_BIT]; // [R15]
    end
  end

  // cause flags: writing 0 clears, a new cause in the same cycle wins;
  // of the resets only the power-on reset clears them so the cause survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swr_flag_reg <= WDS_FLAG_RST;
      ovf_flag_reg <= WDS_FLAG_RST;
    end else begin
      if (seq_swr || seq_err) begin
        swr_flag_reg <= 1'b1; // [R12] [R13] [R16]
      end else if (ctl_wr && !sfr_req.wdata[WDS_SWR_BIT]) begin
        swr_flag_reg <= 1'b0; // [R14]
      end
      if (timeout || seq_err) begin
        ovf_flag_reg <= 1'b1; // [R13] [R14] [R16]
      end else if (ctl_wr && !sfr_req.wdata[WDS_OVF_BIT]) begin
        ovf_flag_reg <= 1'b0; // [R14]
      end
    end
  end

  // running state: only the sequence sets it, never a direct write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= WDS_RUN_RST;
    end else if (rst_all) begin
      run_reg <= 1'b0; // [R5] [R16]
    end else if (seq_feed) begin
      run_reg <= 1'b1; // [R7] [R8]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tps_cnt_reg <= '0;
      pre_reg <= '0;
      cnt_reg <= '0;
    end else if (rst_all || seq_feed) begin
      tps_cnt_reg <= '0; // [R16]
      pre_reg <= '0;
      cnt_reg <= '0;
    end else if (advance) begin
      if (tick) begin
        tps_cnt_reg <= '0;
        pre_reg <= pre_reg + 1'b1; // [R4]
      end else begin
        tps_cnt_reg <= tps_cnt_reg + 1'b1;
      end
      if (pre_tick) begin
        cnt_reg <= cnt_reg + 1'b1; // [R4]
      end
    end
  end

  // one-cycle reset request to the cpu
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pulse_reg <= 1'b0;
    end else begin
      rst_pulse_reg <= self_rst; // [R6] [R11] [R12] [R13]
    end
  end

  assign ctl_value = {ps_reg, idle_frz_reg, 1'b0, swr_flag_reg,
                      ovf_flag_reg, run_reg};

  // read data registered; sequence register reads as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= WDS_RDATA_RST;
    end else if (sfr_req.rd && sfr_req.addr == WDS_CTL_ADDR) begin
      rdata_reg <= ctl_value; // [R8]
    end else begin
      rdata_reg <= WDS_RDATA_RST;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign cpu_reset_pulse = rst_pulse_reg;

  default clocking wds_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_bad_first_byte: assert property ( // [R13]
    seq_reg == WDS_SEQ_IDLE && seq_wr && !sys_reset &&
    sfr_req.wdata != WDS_FEED_1 && sfr_req.wdata != WDS_SWR_1
    |=> cpu_reset_pulse && swr_flag_reg && ovf_flag_reg && !run_reg
  ) else $error("bad first byte did not reset with both flags");

  a_soft_reset_seq: assert property ( // [R12]
    seq_wr && sfr_req.wdata == WDS_SWR_1 && seq_reg == WDS_SEQ_IDLE
    && !rst_all ##1 seq_wr && sfr_req.wdata == WDS_SWR_2 && !sys_reset
    |=> cpu_reset_pulse && swr_flag_reg && !run_reg
  ) else $error("software reset sequence not honoured");

  a_enable_seq: assert property ( // [R7]
    seq_wr && sfr_req.wdata == WDS_FEED_1 && seq_reg == WDS_SEQ_IDLE
    && !rst_all ##1 seq_wr && sfr_req.wdata == WDS_FEED_2 && !sys_reset
    |=> run_reg && cnt_reg == '0 && pre_reg == '0 && !cpu_reset_pulse
  ) else $error("enable sequence did not start the count");

  a_feed_broken: assert property ( // [R11]
    seq_reg == WDS_SEQ_FEED && !seq_wr && other_wr && !sys_reset
    |=> cpu_reset_pulse && swr_flag_reg && ovf_flag_reg
  ) else $error("interrupted feed did not reset");

  a_run_readonly: assert property ( // [R8]
    ctl_wr && !rst_all && !seq_feed |=> run_reg == $past(run_reg)
  ) else $error("running bit changed by a direct write");

  a_timeout_reset: assert property ( // [R6]
    run_reg && advance && pre_tick && &cnt_reg && !seq_feed
    |=> cpu_reset_pulse && ovf_flag_reg && !run_reg && cnt_reg == '0
  ) else $error("time-out did not reset the cpu");

  a_idle_freeze: assert property ( // [R15]
    cpu_idle && idle_frz_reg && !rst_all && !seq_feed
    |=> $stable(cnt_reg) && $stable(pre_reg) && $stable(tps_cnt_reg)
  ) else $error("count moved while frozen in idle");

  a_power_hold: assert property ( // [R5]
    cpu_power_down && !rst_all && !seq_feed
    |=> $stable(cnt_reg) && $stable(pre_reg) && $stable(tps_cnt_reg)
  ) else $error("count moved during power-down");

  // divider or prescaler always moves on an advancing cycle
  a_idle_counts: assert property ( // [R15]
    run_reg && cpu_idle && !idle_frz_reg && !cpu_power_down &&
    !rst_all && !seq_feed |=> !$stable({tps_cnt_reg, pre_reg})
  ) else $error("count stalled in idle without freeze");

  a_reset_stops: assert property ( // [R5]
    sys_reset && !self_rst
    |=> !run_reg && cnt_reg == '0 && pre_reg == '0 && !cpu_reset_pulse
  ) else $error("watchdog still running after reset");

  a_count_step: assert property ( // [R2] [R4]
    pre_tick && !rst_all && !seq_feed && !(&cnt_reg)
    |=> cnt_reg == $past(cnt_reg) + 1'b1 && (pre_reg & $past(pre_mask))
        == '0
  ) else $error("counter step out of line with prescaler");

  a_flag_keep: assert property ( // [R16]
    swr_flag_reg && !(ctl_wr && !sfr_req.wdata[WDS_SWR_BIT])
    |=> swr_flag_reg
  ) else $error("reset cause flag lost");

  a_cause_clear: assert property ( // [R14]
    ctl_wr && !sfr_req.wdata[WDS_SWR_BIT] &&
    !sfr_req.wdata[WDS_OVF_BIT] && !self_rst
    |=> !swr_flag_reg && !ovf_flag_reg
  ) else $error("cause flags not cleared by software");

  a_readback_run: assert property ( // [R8]
    sfr_req.rd && sfr_req.addr == WDS_CTL_ADDR
    |=> sfr_rdata[WDS_RUN_BIT] == $past(run_reg)
  ) else $error("running bit read back wrong");

  c_enable: cover property (seq_feed && !run_reg);
  c_feed_running: cover property (seq_feed && run_reg);
  c_soft_reset: cover property (seq_swr);
  c_timeout: cover property (timeout);
  c_seq_error: cover property (seq_err);

endmodule : wds_watchdog

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import wds_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wds_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic [WDS_TPS_W-1:0] system_timer_divider_setting = '0;
  logic cpu_idle = 1'b0;
  logic cpu_power_down = 1'b0;
  logic sys_reset = 1'b0;
  logic cpu_reset_pulse;
  logic pulse_seen = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int n;

  always #10 clk = ~clk;

  wds_watchdog wds_watchdog_inst (
    .clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .system_timer_divider_setting(system_timer_divider_setting), .cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down),
    .sys_reset(sys_reset), .cpu_reset_pulse(cpu_reset_pulse));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // one idle cycle after each access; sequences need not be back to back
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
    #1 pulse_seen = cpu_reset_pulse;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1 check("read data", sfr_rdata, exp);
  endtask : rd

  // back-to-back pair, the tightest spacing the bus allows
  task automatic seq(logic [7:0] b1, logic [7:0] b2);
    @(posedge clk);
    sfr_req <= '{addr: WDS_SEQ_ADDR, wr: 1'b1, rd: 1'b0, wdata: b1};
    wr(WDS_SEQ_ADDR, b2);
  endtask : seq

  task automatic t_sequences;
    rd(WDS_CTL_ADDR, 8'h00);
    rd(WDS_SEQ_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    wr(WDS_CTL_ADDR, 8'hff);
    rd(WDS_CTL_ADDR, 8'hf0);
    wr(WDS_CTL_ADDR, 8'h00);
    wr(WDS_SEQ_ADDR, WDS_SWR_1);
    check("pulse", pulse_seen, 1'b0);
    wr(WDS_SEQ_ADDR, WDS_SWR_2);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h04);
    wr(WDS_CTL_ADDR, 8'h00);
    wr(WDS_SEQ_ADDR, 8'h33);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h06);
    wr(WDS_CTL_ADDR, 8'h00);
    wr(WDS_SEQ_ADDR, WDS_FEED_1);
    rd(WDS_CTL_ADDR, 8'h00);
    wr(WDS_SEQ_ADDR, WDS_FEED_2);
    check("pulse", pulse_seen, 1'b0);
    rd(WDS_CTL_ADDR, 8'h01);
    wr(WDS_CTL_ADDR, 8'h00);
    rd(WDS_CTL_ADDR, 8'h01);
    wr(WDS_SEQ_ADDR, WDS_FEED_1);
    wr(WDS_CTL_ADDR, 8'h00);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h06);
    wr(WDS_CTL_ADDR, 8'h00);
    seq(WDS_SWR_1, WDS_FEED_2);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h06);
    wr(WDS_CTL_ADDR, 8'h00);
    seq(WDS_FEED_1, WDS_SWR_2);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h06);
    wr(WDS_CTL_ADDR, 8'h00);
    wr(WDS_SEQ_ADDR, WDS_SWR_1);
    wr(8'h10, 8'h00);
    check("pulse", pulse_seen, 1'b1);
    rd(WDS_CTL_ADDR, 8'h06);
    wr(WDS_CTL_ADDR, 8'h00);
  endtask : t_sequences

  // flags must survive a system reset that stops the count
  task automatic t_sys_reset;
    seq(WDS_SWR_1, WDS_SWR_2);
    seq(WDS_FEED_1, WDS_FEED_2);
    rd(WDS_CTL_ADDR, 8'h05);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    rd(WDS_CTL_ADDR, 8'h04);
    wr(WDS_CTL_ADDR, 8'h00);
  endtask : t_sys_reset

  task automatic run_to(logic [2:0] ps, logic [3:0] t, logic fz,
                        logic pd, int stall, int pre);
    int exp;
    exp = (1 << (ps + 14)) * (t + 1) + ((fz || pd) ? stall : 0);
    @(posedge clk);
    system_timer_divider_setting <= t;
    wr(WDS_CTL_ADDR, {ps, fz, 4'h0});
    seq(WDS_FEED_1, WDS_FEED_2);
    if (pre > 0) begin
      repeat (pre) @(posedge clk);
      seq(WDS_FEED_1, WDS_FEED_2);
    end
    for (n = 1; n < exp + 10; n++) begin
      @(posedge clk);
      cpu_idle <= !pd && n <= stall;
      cpu_power_down <= pd && n <= stall;
      #1;
      if (cpu_reset_pulse === 1'b1) break;
    end
    check("period", n, exp);
    @(posedge clk);
    #1 check("pulse width", cpu_reset_pulse, 1'b0);
    rd(WDS_CTL_ADDR, 8'h02);
    wr(WDS_CTL_ADDR, 8'h00);
  endtask : run_to

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // the timed runs need just under 100k cycles in all
  initial begin
    repeat (105000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog limit reached");
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_sequences();
    t_sys_reset();
    run_to(3'h0, 4'h0, 1'b0, 1'b0, 500, 0);
    run_to(3'h0, 4'h0, 1'b1, 1'b0, 700, 200);
    run_to(3'h1, 4'h0, 1'b0, 1'b1, 300, 0);
    run_to(3'h0, 4'h1, 1'b0, 1'b0, 0, 0);
    wrap_up();
  end
endmodule : tb_top
